// ---- hdl/phr_buf.sv ----
// two-entry word buffer with valid/ready on both sides
`timescale 1ns/1ps
module phr_buf
	import phr_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire phr_word_type in_word,
	output logic out_valid,
	input wire logic out_ready,
	output phr_word_type out_word
);

	phr_buf_type s_q;
	phr_buf_type s_d;
	logic push;
	logic pop;

	// honest flags straight from the occupancy count
	assign in_ready = (s_q.cnt != 2'(BUF_DEPTH));
	assign out_valid = (s_q.cnt != 2'h0);
	assign out_word = s_q.mem[s_q.rp];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// pointer and count update; push and pop may share a cycle
	always_comb begin
		s_d = s_q;
		if (push) begin
			s_d.mem[s_q.wp] = in_word;
			s_d.wp = ~s_q.wp;
		end
		if (pop) begin
			s_d.rp = ~s_q.rp;
		end
		s_d.cnt = s_q.cnt + 2'(push) - 2'(pop);
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_q <= BUF_RST;
		end else begin
			s_q <= s_d;
		end
	end

endmodule // phr_buf

// ---- hdl/phr_pkg.sv ----
// shared types and constants of the receive-side mac interface
package phr_pkg;

	// mac interface flavour and line speed
	typedef enum logic [1:0] {
		MODE_MII = 2'h0,
		MODE_GMII = 2'h1,
		MODE_RGMII = 2'h3
	} phr_mode_type;

	typedef enum logic [1:0] {
		SPEED_10 = 2'h0,
		SPEED_100 = 2'h1,
		SPEED_1000 = 2'h3
	} phr_speed_type;

	// mii nibble phase, gray along low -> high
	typedef enum logic {
		PH_LOW = 1'h0,
		PH_HIGH = 1'h1
	} phr_phase_type;

	// one received byte with its error mark
	typedef struct packed {
		logic error;
		logic [7:0] data;
	} phr_word_type;

	localparam int BUF_DEPTH = 2;
	localparam int DIV_W = 6;

	// recovered line clock nominal rate and receive clock rates, kHz
	localparam int LINE_FREQ_KHZ = 250000;
	localparam int RXCLK_10_KHZ = 2500;
	localparam int RXCLK_100_KHZ = 25000;
	localparam int RXCLK_1000_KHZ = 125000;

	// line clock cycles per half period of the receive clock
	localparam logic [DIV_W-1:0] HALF_10 = DIV_W'(LINE_FREQ_KHZ / (2 * RXCLK_10_KHZ));
	localparam logic [DIV_W-1:0] HALF_100 = DIV_W'(LINE_FREQ_KHZ / (2 * RXCLK_100_KHZ));
	localparam logic [DIV_W-1:0] HALF_1000 = DIV_W'(LINE_FREQ_KHZ / (2 * RXCLK_1000_KHZ));

	// core clock side state
	typedef struct packed {
		logic tx_meta;
		logic tx_sync;
		logic ack_meta;
		logic ack_sync;
		logic req;
		phr_word_type hs_word;
		logic col;
		logic crs;
	} phr_core_type;

	// line clock side state
	typedef struct packed {
		phr_mode_type mode_meta;
		phr_mode_type mode_sync;
		phr_speed_type speed_meta;
		phr_speed_type speed_sync;
		logic req_meta;
		logic req_sync;
		logic req_seen;
		logic ack;
		logic have;
		phr_word_type word;
		logic [DIV_W-1:0] div;
		logic clk;
		phr_word_type cur;
		logic cur_ok;
		phr_phase_type phase;
		logic [7:0] rxd;
		logic ctl;
		logic er;
		logic txclk;
	} phr_link_type;

	// two-entry buffer state
	typedef struct packed {
		phr_word_type [BUF_DEPTH-1:0] mem;
		logic wp;
		logic rp;
		logic [1:0] cnt;
	} phr_buf_type;

	localparam phr_core_type CORE_RST = '0;
	localparam phr_link_type LINK_RST = '0;
	localparam phr_buf_type BUF_RST = '0;

	// half period count for a speed, used by both clock outputs
	function automatic logic [DIV_W-1:0] half_count(input phr_speed_type s);
		logic [DIV_W-1:0] h;
		h = HALF_10;
		if (s == SPEED_100) begin
			h = HALF_100;
		end else if (s == SPEED_1000) begin
			h = HALF_1000;
		end
		return h;
	endfunction

endpackage

// ---- hdl/phr_rx_if.sv ----
// receive side of the phy towards the mac: clocks, data lanes, control, col, crs
//
// Behaviour
// [R1] receive clock 2.5, 25 or 125 MHz
// [R2] lanes 0-3 carry data, receive-clock synchronous
// [R3] lanes 4-7 used in gmii only
// [R4] mac raises transmit enable with data
// [R5] mac multiplexes enable and error in rgmii
// [R6] data valid high while data presented
// [R7] rgmii control: valid rising, error falling
// [R8] receive error high on detected error
// [R9] separate receive error unused in rgmii
// [R10] collision on simultaneous activity, half duplex
// [R11] collision low in full duplex
// [R12] collision unused in rgmii
// [R13] half duplex carrier sense on any activity
// [R14] full duplex carrier only on receive; CRS held low in full duplex at 1000 speed
// [R15] carrier sense unused in rgmii
// [R16] mac supplies 125 MHz transmit clock
// [R17] mii: device drives transmit clock
// [R18] rgmii byte: low nibble rising, high falling
`timescale 1ns/1ps
module phr_rx_if
	import phr_pkg::*;
(
	input wire logic MCLK,
	input wire logic RESET,
	input wire logic LINE_CLK,
	input wire phr_mode_type MODE,
	input wire phr_speed_type SPEED,
	input wire logic FULL_DUPLEX,
	input wire logic RX_CARRIER,
	input wire logic IN_VALID,
	output logic IN_READY,
	input wire phr_word_type IN_WORD,
	input wire logic TX_EN_CTRL,
	output logic RX_CLK,
	output logic [7:0] RXD,
	output logic RX_VALID_CTRL,
	output logic RX_ER,
	output logic COL,
	output logic CRS,
	output logic TX_CLK
);

	// core clock domain state
	phr_core_type c_q;
	phr_core_type c_d;

	// line clock domain state
	phr_link_type l_q;
	phr_link_type l_d;

	// reset carried into the line domain
	logic rst_meta;
	logic rst_link;

	// buffer output towards the crossing
	logic buf_valid;
	logic buf_ready;
	phr_word_type buf_word;

	// helper terms of the core domain
	logic hs_idle;
	logic tx_active;

	// helper terms of the line domain
	logic tick;
	logic falling;
	logic rising;
	logic take;

	// a stall downstream back-pressures IN_READY, so no word is lost
	phr_buf phr_buf_inst (
		.clk(MCLK),
		.rst(RESET),
		.in_valid(IN_VALID),
		.in_ready(IN_READY),
		.in_word(IN_WORD),
		.out_valid(buf_valid),
		.out_ready(buf_ready),
		.out_word(buf_word)
	);

	// core domain: crossing request side and the status pins
	assign hs_idle = (c_q.req == c_q.ack_sync);
	assign buf_ready = hs_idle;
	assign tx_active = c_q.tx_sync; // R4

	always_comb begin
		c_d = c_q;
		// transmit enable comes from the mac pin, so two flops first
		c_d.tx_meta = TX_EN_CTRL;
		c_d.tx_sync = c_q.tx_meta;
		// acknowledge toggle from the line domain
		c_d.ack_meta = l_q.ack;
		c_d.ack_sync = c_q.ack_meta;
		// one word in flight; data held stable until acknowledged
		if (buf_valid && hs_idle) begin
			c_d.hs_word = buf_word;
			c_d.req = ~c_q.req;
		end
		// collision only in half duplex and never in rgmii
		c_d.col = 1'b0; // R11
		if (MODE != MODE_RGMII && !FULL_DUPLEX) begin // R12
			c_d.col = tx_active && RX_CARRIER; // R10
		end
		// carrier sense per duplex; held low where undefined
		c_d.crs = 1'b0;
		if (MODE != MODE_RGMII) begin // R15
			if (!FULL_DUPLEX) begin
				c_d.crs = tx_active || RX_CARRIER; // R13
			end else if (SPEED != SPEED_1000) begin
				c_d.crs = RX_CARRIER; // R14
			end
		end
	end

	always_ff @(posedge MCLK) begin
		if (RESET) begin
			c_q <= CORE_RST;
		end else begin
			c_q <= c_d;
		end
	end

	// reset release seen by the line domain; may lag by two line edges
	always_ff @(posedge LINE_CLK) begin
		rst_meta <= RESET;
		rst_link <= rst_meta;
	end

	// line domain timing terms
	assign tick = (l_q.div == DIV_W'(0));
	assign falling = tick && l_q.clk;
	assign rising = tick && !l_q.clk;
	assign take = (l_q.req_sync != l_q.req_seen) && !l_q.have;

	// line domain: clock divider, word take-over and lane launch
	always_comb begin
		l_d = l_q;
		// configuration levels crossing from the core domain
		l_d.mode_meta = MODE;
		l_d.mode_sync = l_q.mode_meta;
		l_d.speed_meta = SPEED;
		l_d.speed_sync = l_q.speed_meta;
		// request toggle crossing; word is stable once it is seen
		l_d.req_meta = c_q.req;
		l_d.req_sync = l_q.req_meta;
		if (take) begin
			l_d.word = c_q.hs_word;
			l_d.have = 1'b1;
			l_d.req_seen = l_q.req_sync;
			l_d.ack = ~l_q.ack;
		end
		// receive clock: half period counted in line clock cycles
		if (tick) begin
			l_d.div = half_count(l_q.speed_sync) - DIV_W'(1); // R1
			l_d.clk = ~l_q.clk; // R1
		end else begin
			l_d.div = l_q.div - DIV_W'(1);
		end
		// sdr data launched on falling edges so the mac samples at rising
		unique case (l_q.mode_sync)
			MODE_GMII: begin
				if (falling) begin
					if (l_q.have) begin
						l_d.rxd = l_q.word.data; // R2 R3
						l_d.ctl = 1'b1; // R6
						l_d.er = l_q.word.error; // R8
						l_d.have = 1'b0;
					end else begin
						l_d.rxd = 8'h00;
						l_d.ctl = 1'b0;
						l_d.er = 1'b0;
					end
				end
			end
			MODE_MII: begin
				// a byte takes two receive clocks, low nibble first
				if (falling) begin
					l_d.rxd[7:4] = 4'h0; // R3
					unique case (l_q.phase)
						PH_HIGH: begin
							l_d.rxd[3:0] = l_q.cur.data[7:4]; // R2
							l_d.ctl = 1'b1; // R6
							l_d.er = l_q.cur.error; // R8
							l_d.phase = PH_LOW;
						end
						PH_LOW: begin
							if (l_q.have) begin
								l_d.rxd[3:0] = l_q.word.data[3:0]; // R2
								l_d.ctl = 1'b1; // R6
								l_d.er = l_q.word.error; // R8
								l_d.cur = l_q.word;
								l_d.have = 1'b0;
								l_d.phase = PH_HIGH;
							end else begin
								l_d.rxd[3:0] = 4'h0;
								l_d.ctl = 1'b0;
								l_d.er = 1'b0;
							end
						end
					endcase
				end
			end
			MODE_RGMII: begin
				// both edges used; separate error pin stays low
				l_d.er = 1'b0; // R9
				l_d.rxd[7:4] = 4'h0; // R3
				if (falling) begin
					// set up low nibble and valid for the rising edge
					if (l_q.have) begin
						l_d.rxd[3:0] = l_q.word.data[3:0]; // R18
						l_d.ctl = 1'b1; // R7
						l_d.cur = l_q.word;
						l_d.cur_ok = 1'b1;
						l_d.have = 1'b0;
					end else begin
						l_d.rxd[3:0] = 4'h0;
						l_d.ctl = 1'b0;
						l_d.cur_ok = 1'b0;
					end
				end else if (rising) begin
					// set up high nibble and error for the falling edge
					l_d.rxd[3:0] = l_q.cur_ok ? l_q.cur.data[7:4] : 4'h0; // R18
					l_d.ctl = l_q.cur_ok && l_q.cur.error; // R7
				end
			end
			default: begin
				// undefined mode code: lanes idle
				l_d.rxd = 8'h00;
				l_d.ctl = 1'b0;
				l_d.er = 1'b0;
			end
		endcase
		// mii transmit clock follows the receive divider; low otherwise
		l_d.txclk = (l_q.mode_sync == MODE_MII) ? l_d.clk : 1'b0; // R17
	end

	always_ff @(posedge LINE_CLK) begin
		if (rst_link) begin
			l_q <= LINK_RST;
		end else begin
			l_q <= l_d;
		end
	end

	// every pin output but IN_READY comes straight from a flip-flop
	assign RX_CLK = l_q.clk;
	assign RXD = l_q.rxd;
	assign RX_VALID_CTRL = l_q.ctl;
	assign RX_ER = l_q.er;
	assign TX_CLK = l_q.txclk;
	assign COL = c_q.col;
	assign CRS = c_q.crs;

endmodule // phr_rx_if

// ---- sim/phr_mac_model.sv ----
// mac side model collecting the delivered bytes
`timescale 1ns/1ps
module phr_mac_model
	import phr_pkg::*;
(
	input wire logic line_clk,
	input wire phr_mode_type mode,
	input wire logic rx_clk,
	input wire logic [7:0] rxd,
	input wire logic ctl,
	input wire logic er,
	input wire logic tx_req,
	output logic tx_en
);
	phr_word_type got[$];
	logic [3:0] lo, rg_lo;
	logic half = 0, lo_er, rg_half = 0;
	// continuous transmit clock owed to the phy in gmii and rgmii; no receive pin takes it
	logic gtx_clk = 0;
	always #4 gtx_clk = (mode == MODE_MII) ? 1'b0 : ~gtx_clk;
	// enable raised only while the mac has data to send
	assign tx_en = tx_req;
	// sdr capture on the rise, data launched at the fall
	always @(posedge rx_clk) begin
		if (mode == MODE_RGMII) begin
		end else if (!ctl) begin
			half = 0;
		end else if (mode == MODE_GMII) begin
			got.push_back({er, rxd});
		end else if (half) begin
			got.push_back({er | lo_er, rxd[3:0], lo});
			half = 0;
		end else begin
			lo = rxd[3:0];
			lo_er = er;
			half = 1;
		end
	end
	// ddr capture mid half period: valid and low nibble stand for the rising edge,
	// error and high nibble for the falling edge
	always @(negedge line_clk) begin
		if (mode == MODE_RGMII && !rx_clk && ctl) begin
			rg_lo = rxd[3:0];
			rg_half = 1;
		end else if (mode == MODE_RGMII && rx_clk && rg_half) begin
			got.push_back({ctl, rxd[3:0], rg_lo});
			rg_half = 0;
		end
	end
endmodule // phr_mac_model

// ---- sim/phr_rx_if_chk.sv ----
// assertions on the receive interface ports
`timescale 1ns/1ps
module phr_rx_if_chk
	import phr_pkg::*;
(
	input wire logic MCLK,
	input wire logic RESET,
	input wire logic LINE_CLK,
	input wire phr_mode_type MODE,
	input wire phr_speed_type SPEED,
	input wire logic FULL_DUPLEX,
	input wire logic RX_CARRIER,
	input wire logic [7:0] RXD,
	input wire logic RX_ER,
	input wire logic COL,
	input wire logic CRS,
	input wire logic TX_CLK
);
	property p_col_fd;
		@(posedge MCLK) disable iff (RESET) FULL_DUPLEX |=> !COL;
	endproperty
	a_col_fd: assert property (p_col_fd) else $error("col in full duplex");
	property p_col_cause;
		@(posedge MCLK) disable iff (RESET) COL |-> $past(RX_CARRIER) && !$past(FULL_DUPLEX);
	endproperty
	a_col_cause: assert property (p_col_cause) else $error("col without cause");
	property p_crs_rg;
		@(posedge MCLK) disable iff (RESET) MODE == MODE_RGMII |=> !CRS;
	endproperty
	a_crs_rg: assert property (p_crs_rg) else $error("crs in rgmii");
	property p_crs_half;
		@(posedge MCLK) disable iff (RESET)
			MODE != MODE_RGMII && !FULL_DUPLEX && RX_CARRIER |=> CRS;
	endproperty
	a_crs_half: assert property (p_crs_half) else $error("crs missing");
	property p_crs_full;
		@(posedge MCLK) disable iff (RESET) MODE != MODE_RGMII && FULL_DUPLEX &&
			SPEED != SPEED_1000 |=> CRS == $past(RX_CARRIER);
	endproperty
	a_crs_full: assert property (p_crs_full) else $error("crs full duplex");
	// line side lags mode changes by its synchroniser, hence the history guard
	property p_er_rg;
		@(posedge LINE_CLK) disable iff (RESET)
			MODE == MODE_RGMII && $past(MODE, 5) == MODE_RGMII |-> !RX_ER;
	endproperty
	a_er_rg: assert property (p_er_rg) else $error("rx_er in rgmii");
	property p_hi_lanes;
		@(posedge LINE_CLK) disable iff (RESET)
			MODE != MODE_GMII && $past(MODE, 5) != MODE_GMII |-> RXD[7:4] == 4'h0;
	endproperty
	a_hi_lanes: assert property (p_hi_lanes) else $error("high lanes used");
	property p_txclk;
		@(posedge LINE_CLK) disable iff (RESET)
			MODE != MODE_MII && $past(MODE, 5) != MODE_MII |-> !TX_CLK;
	endproperty
	a_txclk: assert property (p_txclk) else $error("tx_clk outside mii");
endmodule // phr_rx_if_chk

bind phr_rx_if phr_rx_if_chk phr_rx_if_chk_inst (.MCLK(MCLK), .RESET(RESET),
	.LINE_CLK(LINE_CLK), .MODE(MODE), .SPEED(SPEED), .FULL_DUPLEX(FULL_DUPLEX),
	.RX_CARRIER(RX_CARRIER), .RXD(RXD), .RX_ER(RX_ER), .COL(COL), .CRS(CRS), .TX_CLK(TX_CLK));

// ---- sim/tb_phr_rx_if.sv ----
// testbench of the receive interface against the mac model
`timescale 1ns/1ps
module tb_phr_rx_if
	import phr_pkg::*;
;
	logic MCLK = 0, RESET = 1, LINE_CLK = 0, FULL_DUPLEX = 0, RX_CARRIER = 0, IN_VALID = 0;
	logic tx_req = 0, TX_EN_CTRL, IN_READY, RX_CLK, RX_VALID_CTRL, RX_ER, COL, CRS, TX_CLK;
	phr_mode_type MODE = MODE_MII;
	phr_speed_type SPEED = SPEED_10;
	phr_word_type IN_WORD = '0;
	logic [7:0] RXD;
	int fails = 0, comparisons = 0;
	always #5 MCLK = ~MCLK;
	// offset keeps line edges off the core edges
	always begin
		#13;
		forever #40 LINE_CLK = ~LINE_CLK;
	end
	phr_rx_if phr_rx_if_inst (.MCLK(MCLK), .RESET(RESET), .LINE_CLK(LINE_CLK), .MODE(MODE),
		.SPEED(SPEED), .FULL_DUPLEX(FULL_DUPLEX), .RX_CARRIER(RX_CARRIER), .IN_VALID(IN_VALID),
		.IN_READY(IN_READY), .IN_WORD(IN_WORD), .TX_EN_CTRL(TX_EN_CTRL), .RX_CLK(RX_CLK),
		.RXD(RXD), .RX_VALID_CTRL(RX_VALID_CTRL), .RX_ER(RX_ER), .COL(COL), .CRS(CRS),
		.TX_CLK(TX_CLK));
	phr_mac_model phr_mac_model_inst (.line_clk(LINE_CLK), .mode(MODE), .rx_clk(RX_CLK),
		.rxd(RXD), .ctl(RX_VALID_CTRL), .er(RX_ER), .tx_req(tx_req), .tx_en(TX_EN_CTRL));
	task automatic check(string name, logic [15:0] exp, logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic end_of_test();
		if (fails == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic tick(int n);
		repeat (n) @(posedge MCLK);
		#1;
	endtask
	function automatic phr_word_type word(int k);
		return {k == 1, 8'h5a ^ 8'(k * 37)};
	endfunction
	// every duplex, carrier and transmit combination, at 100 and 1000 speed in mii and rgmii
	task automatic t_colcrs();
		int k;
		logic col, crs;
		for (k = 0; k < 32; k++) begin
			tx_req = k[0];
			RX_CARRIER = k[1];
			FULL_DUPLEX = k[2];
			SPEED = k[3] ? SPEED_1000 : SPEED_100;
			MODE = k[4] ? MODE_RGMII : MODE_MII;
			tick(6);
			col = !k[4] && !k[2] && k[0] && k[1];
			crs = !k[4] && (k[2] ? k[1] && !k[3] : k[0] || k[1]);
			check("col", 16'(col), 16'(COL));
			check("crs", 16'(crs), 16'(CRS));
		end
	endtask
	// a frame fed faster than the line drains it, so the buffer refuses
	task automatic t_stream(phr_mode_type m, phr_speed_type s, int n, int per);
		int k;
		realtime t0;
		logic full;
		MODE = m;
		SPEED = s;
		full = 0;
		phr_mac_model_inst.got.delete();
		tick(40);
		@(posedge RX_CLK);
		t0 = $realtime;
		@(posedge RX_CLK);
		check("rx_clk period", 16'(per), 16'(int'($realtime - t0)));
		if (m == MODE_MII) begin
			@(posedge TX_CLK);
			t0 = $realtime;
			@(posedge TX_CLK);
			check("tx_clk period", 16'(per), 16'(int'($realtime - t0)));
		end
		tick(1);
		for (k = 0; k < n; k++) begin
			IN_VALID = 1;
			IN_WORD = word(k);
			while (IN_READY !== 1) begin
				full = 1;
				tick(1);
			end
			tick(1);
		end
		IN_VALID = 0;
		for (k = 0; k < 20000 && phr_mac_model_inst.got.size() < n; k++) begin
			tick(1);
		end
		check("count", 16'(n), 16'(phr_mac_model_inst.got.size()));
		for (k = 0; k < n && k < phr_mac_model_inst.got.size(); k++) begin
			check("word", 16'(word(k)), 16'(phr_mac_model_inst.got[k]));
		end
		check("refused", 16'h1, 16'(full));
	endtask
	// reset spans three line cycles so the line side clears too
	initial begin
		tick(24);
		RESET = 0;
		tick(4);
		t_colcrs();
		t_stream(MODE_MII, SPEED_10, 4, 8000);
		t_stream(MODE_MII, SPEED_100, 4, 800);
		t_stream(MODE_GMII, SPEED_1000, 6, 160);
		t_stream(MODE_RGMII, SPEED_1000, 5, 160);
		end_of_test();
	end
	// watchdog well past the expected run
	initial begin
		#400000;
		fails++;
		end_of_test();
	end
endmodule // tb_phr_rx_if
